// ==== cjr_exec.sv ====
// Execute unit for exception return, hibernate, jumps and byte loads.
// Assumes the pipeline offers one decoded word with operands per cycle.
`include "cjr_defines.svh"
module cjr_exec (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Instruction and operands
  input  wire logic        insnValid,
  input  wire logic [31:0] insnWord,
  input  wire logic [63:0] pcIn,
  input  wire logic [63:0] srcValue,
  input  wire logic [63:0] baseValue,
  input  wire logic        compactIsaEnable,
  input  wire logic        hibernateWbDone,
  // Return pointers
  input  wire logic [63:0] exceptionReturnPc,
  input  wire logic [63:0] errorReturnPc,
  // Memory byte path
  input  wire logic        loadDataValid,
  input  wire logic [7:0]  loadByte,
  input  wire logic        systemAddrDataBusIdle,
  // Results
  output logic [63:0]      pcOut,
  output logic             isaMode,
  output logic             errorLevelFlag,
  output logic             exceptionLevelFlag,
  output logic             redirectNow,
  output logic             regWriteEn,
  output logic [4:0]       regWriteAddr,
  output logic [63:0]      regWriteData,
  output logic [63:0]      loadAddr,
  output logic             loadReq,
  output logic             reservedInsnFault,
  output logic             fetchAddrError,
  output logic             clocksRunning,
  output logic             pipelineFrozen
);
  // ----------------------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------------------
  wire logic [5:0]  opField   = insnWord[`CJR_OP_HI:`CJR_OP_LO];
  wire logic [5:0]  fnField   = insnWord[`CJR_FN_HI:`CJR_FN_LO];
  wire logic [4:0]  rtField   = insnWord[`CJR_RT_HI:`CJR_RT_LO];
  wire logic [4:0]  rdField   = insnWord[`CJR_RD_HI:`CJR_RD_LO];
  wire logic [25:0] tgtField  = insnWord[`CJR_TGT_HI:0];
  wire logic [15:0] immField  = insnWord[`CJR_IMM_HI:0];
  wire logic        insnLive  = insnValid && clocksRunning;
  wire logic        isSpecial = insnLive && (opField == `CJR_OP_SPECIAL);
  wire logic        isSysCop  = insnLive && (opField == `CJR_OP_SYSCOP) && insnWord[`CJR_CO_BIT];
  wire logic        doEret    = isSysCop && (fnField == `CJR_FN_EXCEPTION_RETURN_INSN);
  wire logic        doHib     = isSysCop && (fnField == `CJR_FN_HIB);
  wire logic        doJabs    = insnLive && (opField == `CJR_OP_JABS);
  wire logic        doJal     = insnLive && (opField == `CJR_OP_JAL);
  wire logic        isJalx    = insnLive && (opField == `CJR_OP_JUMP_LINK_TOGGLE_ISA);
  wire logic        doJalx    = isJalx && compactIsaEnable;
  wire logic        doJr      = isSpecial && (fnField == `CJR_FN_JR);
  wire logic        doJalr    = isSpecial && (fnField == `CJR_FN_JUMP_LINK_VIA_REGISTER);
  wire logic        doLbs     = insnLive && (opField == `CJR_OP_LBS);
  wire logic        doLbu     = insnLive && (opField == `CJR_OP_LBU);

  // ----------------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------------
  logic [63:0] pcQ;
  logic [63:0] pcD;
  logic        isaModeQ;
  logic        isaModeD;
  logic [31:0] srQ;
  logic [31:0] srD;
  logic        pendQ;
  logic        pendD;
  logic [63:0] pendPcQ;
  logic [63:0] pendPcD;
  logic        pendIsaQ;
  logic        pendIsaD;
  logic        pendChkQ;
  logic        pendChkD;
  logic        loadPendQ;
  logic        loadPendD;
  logic        loadSignedQ;
  logic        loadSignedD;
  logic [4:0]  loadDestQ;
  logic [4:0]  loadDestD;
  logic        linkEnQ;
  logic [4:0]  linkAddrQ;
  logic [63:0] linkDataQ;
  logic        redirectQ;
  logic        faultQ;
  logic        addrErrQ;
  logic [63:0] loadAddrQ;
  logic        loadReqQ;

  // ----------------------------------------------------------------------------
  // Target and link formation
  // ----------------------------------------------------------------------------
  // region plus shifted target
  wire logic [63:0] delaySlotPc = pcIn + `CJR_PC_STEP4;
  wire logic [63:0] absTarget   = {delaySlotPc[63:`CJR_REGION_LO], tgtField, 2'b00};
  wire logic [63:0] linkPlain   = pcIn + `CJR_PC_STEP8;
  wire logic [63:0] linkValue   = compactIsaEnable ? {linkPlain[63:1], isaModeQ}
                                                   : linkPlain;
  // clear bit 0 in compact mode
  wire logic [63:0] regTarget   = compactIsaEnable ? {srcValue[63:1], 1'b0} : srcValue;
  wire logic [63:0] eretSrc     = srQ[`CJR_SR_ERL] ? errorReturnPc : exceptionReturnPc;
  // clear bit 0 in compact mode
  wire logic [63:0] eretTarget  = compactIsaEnable ? {eretSrc[63:1], 1'b0} : eretSrc;
  wire logic [63:0] effAddr     = baseValue + {{48{immField[`CJR_IMM_SIGN]}}, immField};
  wire logic        anyJump     = doJabs || doJal || doJalx || doJr || doJalr;
  wire logic        anyLink     = doJal || doJalx || doJalr;

  // Next-state of control flow
  always_comb begin
    pcD      = pcQ;
    isaModeD = isaModeQ;
    srD      = srQ;
    pendD    = pendQ;
    pendPcD  = pendPcQ;
    pendIsaD = pendIsaQ;
    pendChkD = 1'b0;
    if (insnLive) begin
      pcD = delaySlotPc;
    end
    // Delay slot has issued: take the pending jump
    if (pendQ && insnLive) begin
      pcD      = pendPcQ;
      isaModeD = pendIsaQ;
      pendD    = 1'b0;
      pendChkD = 1'b1;
    end
    if (doEret) begin
      pcD = eretTarget;
      if (compactIsaEnable) begin
        isaModeD = eretSrc[0];
      end
      if (srQ[`CJR_SR_ERL]) begin
        srD[`CJR_SR_ERL] = 1'b0;
      end else begin
        srD[`CJR_SR_EXL] = 1'b0;
      end
      pendD = 1'b0;
    end else if (anyJump && !pendQ) begin
      pendD    = 1'b1;
      pendIsaD = isaModeQ;
      if (doJabs || doJal) begin
        pendPcD = absTarget;
      end else if (doJalx) begin
        pendPcD  = absTarget;
        pendIsaD = ~isaModeQ;
      end else begin
        pendPcD = regTarget;
        if (compactIsaEnable) begin
          pendIsaD = srcValue[0];
        end
      end
    end
  end

  // Next-state of byte load tracking
  always_comb begin
    loadPendD   = loadPendQ;
    loadSignedD = loadSignedQ;
    loadDestD   = loadDestQ;
    if (loadPendQ && loadDataValid) begin
      loadPendD = 1'b0;
    end
    if (doLbs || doLbu) begin
      loadPendD   = 1'b1;
      loadSignedD = doLbs;
      loadDestD   = rtField;
    end
  end

  // Link write target
  wire logic [4:0] linkDest = doJalr ? rdField : `CJR_LINK_REG;
  wire logic       misalign = pendChkQ && !isaModeQ && (pcQ[1:0] != 2'b00);

  // Control-flow registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pcQ      <= `CJR_PC_RESET;
      isaModeQ <= 1'b0;
      srQ      <= `CJR_SR_RESET;
      pendQ    <= 1'b0;
      pendPcQ  <= '0;
      pendIsaQ <= 1'b0;
      pendChkQ <= 1'b0;
    end else begin
      pcQ      <= pcD;
      isaModeQ <= isaModeD;
      srQ      <= srD;
      pendQ    <= pendD;
      pendPcQ  <= pendPcD;
      pendIsaQ <= pendIsaD;
      pendChkQ <= pendChkD;
    end
  end

  // Load tracking registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      loadPendQ   <= 1'b0;
      loadSignedQ <= 1'b0;
      loadDestQ   <= '0;
      loadAddrQ   <= '0;
      loadReqQ    <= 1'b0;
    end else begin
      loadPendQ   <= loadPendD;
      loadSignedQ <= loadSignedD;
      loadDestQ   <= loadDestD;
      loadReqQ    <= doLbs || doLbu;
      if (doLbs || doLbu) begin
        loadAddrQ <= effAddr;
      end
    end
  end

  // Result registers: link write has priority, a byte returning in a link cycle is dropped
  wire logic byteWrite = loadPendQ && loadDataValid && !anyLink;
  wire logic [63:0] byteExt = loadSignedQ ? {{56{loadByte[7]}}, loadByte}
                                          : {56'h0, loadByte};
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      linkEnQ   <= 1'b0;
      linkAddrQ <= '0;
      linkDataQ <= '0;
      redirectQ <= 1'b0;
      faultQ    <= 1'b0;
      addrErrQ  <= 1'b0;
    end else begin
      linkEnQ   <= anyLink || byteWrite;
      linkAddrQ <= anyLink ? linkDest : loadDestQ;
      linkDataQ <= anyLink ? linkValue : byteExt;
      redirectQ <= doEret || (pendQ && insnLive);
      faultQ    <= isJalx && !compactIsaEnable;
      addrErrQ  <= misalign;
    end
  end

  // ----------------------------------------------------------------------------
  // Hibernate sequencer
  // ----------------------------------------------------------------------------
  cjr_pwr_if pwrBus ();
  assign pwrBus.hibernateDone = hibernateWbDone || doHib;
  assign pwrBus.busIdle       = systemAddrDataBusIdle;
  cjr_clock_stop uClockStop (
    .clk   (clk),
    .reset (reset),
    .pwr   (pwrBus.ctrl)
  );

  // Output drive
  assign pcOut              = pcQ;
  assign isaMode            = isaModeQ;
  assign errorLevelFlag     = srQ[`CJR_SR_ERL];
  assign exceptionLevelFlag = srQ[`CJR_SR_EXL];
  assign redirectNow        = redirectQ;
  assign regWriteEn         = linkEnQ;
  assign regWriteAddr       = linkAddrQ;
  assign regWriteData       = linkDataQ;
  assign loadAddr           = loadAddrQ;
  assign loadReq            = loadReqQ;
  assign reservedInsnFault  = faultQ;
  assign fetchAddrError     = addrErrQ;
  assign clocksRunning      = pwrBus.clocksOn;
  assign pipelineFrozen     = pwrBus.pipeFrozen;
endmodule : cjr_exec

// ==== cjr_defines.svh ====
// Constants for the jump, return, hibernate and byte-load execute block.
// Assumes inclusion by bare name from the package and the modules.
`ifndef CJR_DEFINES_SVH
`define CJR_DEFINES_SVH
// ----------------------------------------------------------------------------
// Opcode and function fields
// ----------------------------------------------------------------------------
`define CJR_OP_SPECIAL   6'h00
`define CJR_OP_SYSCOP    6'h10
`define CJR_OP_JABS      6'h02
`define CJR_OP_JAL       6'h03
`define CJR_OP_JUMP_LINK_TOGGLE_ISA      6'h1d
`define CJR_OP_LBS       6'h20
`define CJR_OP_LBU       6'h24
`define CJR_FN_JR        6'h08
`define CJR_FN_JUMP_LINK_VIA_REGISTER      6'h09
`define CJR_FN_EXCEPTION_RETURN_INSN      6'h18
`define CJR_FN_HIB       6'h23
`define CJR_CO_BIT       25
`define CJR_OP_HI        31
`define CJR_OP_LO        26
`define CJR_RS_HI        25
`define CJR_RS_LO        21
`define CJR_RT_HI        20
`define CJR_RT_LO        16
`define CJR_RD_HI        15
`define CJR_RD_LO        11
`define CJR_FN_HI        5
`define CJR_FN_LO        0
`define CJR_TGT_HI       25
`define CJR_IMM_HI       15
`define CJR_IMM_SIGN     15
// ----------------------------------------------------------------------------
// Status bits, link register, reset values
// ----------------------------------------------------------------------------
`define CJR_SR_EXL       1
`define CJR_SR_ERL       2
`define CJR_LINK_REG     5'h1f
`define CJR_PC_STEP8     64'h0000_0000_0000_0008
`define CJR_PC_STEP4     64'h0000_0000_0000_0004
`define CJR_PC_RESET     64'hffff_ffff_bfc0_0000
`define CJR_SR_RESET     32'h0000_0004
`define CJR_REGION_LO    28
`endif

// ==== cjr_pkg.sv ====
// Types for the execute block's clock-stop helper; the execute block itself uses none of them.
// Assumes cjr_defines.svh is on the include path.
package cjr_pkg;
  typedef enum logic [1:0] {
    CJR_RUN,
    CJR_WAIT_IDLE,
    CJR_ASLEEP
  } cjr_pwr_type;
  typedef logic [63:0] cjr_word_type;
endpackage : cjr_pkg

// ==== cjr_pwr_if.sv ====
// Carrier between the execute block and the clock-stop helper.
// Assumes both ends share the core clock.
interface cjr_pwr_if;
  logic hibernateDone;
  logic busIdle;
  logic clocksOn;
  logic pipeFrozen;
  modport core (output hibernateDone, output busIdle, input clocksOn, input pipeFrozen);
  modport ctrl (input hibernateDone, input busIdle, output clocksOn, output pipeFrozen);
endinterface : cjr_pwr_if

// ==== cjr_clock_stop.sv ====
// Hibernate sequencer: waits for an idle bus, then gates the clocks off.
// Assumes only reset (cold reset) brings the clocks back.
module cjr_clock_stop (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Power carrier
  cjr_pwr_if.ctrl   pwr
);
  cjr_pkg::cjr_pwr_type stateQ;
  cjr_pkg::cjr_pwr_type stateD;
  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  // wait idle, stop
  always_comb begin
    stateD = stateQ;
    case (stateQ)
      cjr_pkg::CJR_RUN: begin
        if (pwr.hibernateDone) begin
          stateD = pwr.busIdle ? cjr_pkg::CJR_ASLEEP : cjr_pkg::CJR_WAIT_IDLE;
        end
      end
      cjr_pkg::CJR_WAIT_IDLE: begin
        if (pwr.busIdle) begin
          stateD = cjr_pkg::CJR_ASLEEP;
        end
      end
      cjr_pkg::CJR_ASLEEP: stateD = cjr_pkg::CJR_ASLEEP;
      default: stateD = cjr_pkg::CJR_RUN;
    endcase
  end
  // State register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stateQ <= cjr_pkg::CJR_RUN;
    end else begin
      stateQ <= stateD;
    end
  end
  // Clock enable and freeze outputs
  assign pwr.clocksOn   = (stateQ != cjr_pkg::CJR_ASLEEP);
  assign pwr.pipeFrozen = (stateQ != cjr_pkg::CJR_RUN);
endmodule : cjr_clock_stop

// ==== cjr_exec_checker.sv ====
// Concurrent checks on the execute block's ports.
// Assumes the bench drives inputs away from the rising edge.
`include "cjr_defines.svh"
module cjr_exec_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Inputs
  input wire logic        insnValid,
  input wire logic [31:0] insnWord,
  input wire logic [63:0] pcIn,
  input wire logic [63:0] baseValue,
  input wire logic        compactIsaEnable,
  input wire logic [63:0] exceptionReturnPc,
  input wire logic [63:0] errorReturnPc,
  input wire logic        loadDataValid,
  input wire logic [7:0]  loadByte,
  input wire logic        systemAddrDataBusIdle,
  // Outputs
  input wire logic [63:0] pcOut,
  input wire logic        isaMode,
  input wire logic        errorLevelFlag,
  input wire logic        exceptionLevelFlag,
  input wire logic        redirectNow,
  input wire logic        regWriteEn,
  input wire logic [4:0]  regWriteAddr,
  input wire logic [63:0] regWriteData,
  input wire logic [63:0] loadAddr,
  input wire logic        loadReq,
  input wire logic        reservedInsnFault,
  input wire logic        clocksRunning
);
  timeunit 1ns;
  timeprecision 1ns;
  logic loadSigned_q;
  // Decoded requests and expected results
  wire logic [5:0]  opField = insnWord[31:26];
  wire logic        eretGo  = insnValid && insnWord == 32'h4200_0018;
  wire logic [63:0] retSel  = errorLevelFlag ? errorReturnPc : exceptionReturnPc;
  wire logic [63:0] retPc   = compactIsaEnable ? {retSel[63:1], 1'b0} : retSel;
  wire logic [63:0] pcPlus8 = pcIn + 64'h8;
  wire logic [63:0] linkVal = compactIsaEnable ? {pcPlus8[63:1], isaMode} : pcPlus8;
  wire logic        jalGo   = insnValid && (opField == 6'h03 ||
                                            (opField == 6'h1d && compactIsaEnable));
  wire logic        jalrGo  = insnValid && opField == 6'h00 && insnWord[5:0] == 6'h09;
  wire logic        ldGo    = insnValid && (opField == 6'h20 || opField == 6'h24);
  wire logic [63:0] effAddr = baseValue + {{48{insnWord[15]}}, insnWord[15:0]};
  wire logic [63:0] extByte = loadSigned_q ? {{56{loadByte[7]}}, loadByte} : {56'h0, loadByte};
  // Kind of the outstanding byte load
  always_ff @(posedge clk or posedge reset) begin
    if (reset) loadSigned_q <= 1'b0;
    else if (ldGo) loadSigned_q <= opField == 6'h20;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  exception_return_insn_target_a: assert property (eretGo |=> redirectNow && pcOut == $past(retPc))
    else $error("return target wrong");
  exception_return_insn_erl_a: assert property (eretGo && errorLevelFlag |=> !errorLevelFlag)
    else $error("error level not cleared");
  exception_return_insn_exl_a: assert property (eretGo && !errorLevelFlag |=> !exceptionLevelFlag)
    else $error("exception level not cleared");
  jal_link_a: assert property (jalGo |=> regWriteEn && regWriteAddr == 5'h1f &&
    regWriteData == $past(linkVal)) else $error("absolute link wrong");
  jump_link_via_register_link_a: assert property (jalrGo |=> regWriteEn && !reservedInsnFault &&
    regWriteAddr == $past(insnWord[15:11]) && regWriteData == $past(linkVal))
    else $error("register link wrong");
  jump_link_toggle_isa_fault_a: assert property (insnValid && opField == 6'h1d && !compactIsaEnable
    |=> reservedInsnFault && !regWriteEn) else $error("no reserved fault");
  load_addr_a: assert property (ldGo |=> loadReq && loadAddr == $past(effAddr))
    else $error("load address wrong");
  load_data_a: assert property (loadDataValid && !jalGo && !jalrGo |=>
    regWriteEn && regWriteData == $past(extByte)) else $error("load data wrong");
  hib_wait_a: assert property (clocksRunning && !systemAddrDataBusIdle |=> clocksRunning)
    else $error("clocks stopped on busy bus");
  hib_hold_a: assert property (!clocksRunning |=> !clocksRunning && $stable(pcOut))
    else $error("woke without reset");
endmodule : cjr_exec_checker
bind cjr_exec cjr_exec_checker u_chk (.clk, .reset, .insnValid, .insnWord, .pcIn, .baseValue,
  .compactIsaEnable, .exceptionReturnPc, .errorReturnPc, .loadDataValid, .loadByte,
  .systemAddrDataBusIdle, .pcOut, .isaMode, .errorLevelFlag, .exceptionLevelFlag,
  .redirectNow, .regWriteEn, .regWriteAddr, .regWriteData, .loadAddr, .loadReq,
  .reservedInsnFault, .clocksRunning);

// ==== cjr_mem_model.sv ====
// Memory and bus side: answers byte loads, reports bus idle.
// Assumes loadReq is a one-cycle pulse; only one load in flight.
module cjr_mem_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Requests
  input  wire logic        loadReq,
  input  wire logic [63:0] loadAddr,
  input  wire logic        slow,
  input  wire logic        busHold,
  // Answers
  output logic             loadDataValid,
  output logic [7:0]       loadByte,
  output logic             systemAddrDataBusIdle
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] wait_q;
  logic [7:0] byte_q;
  // Bus busy while a load is in flight or held
  assign systemAddrDataBusIdle = !busHold && wait_q == 3'h0;
  // Byte equals the low address byte; data lines toggle between answers
  always_ff @(negedge clk or posedge reset) begin
    if (reset) begin
      wait_q <= 3'h0;
      byte_q <= 8'h00;
      loadDataValid <= 1'b0;
      loadByte <= 8'hff;
    end else begin
      loadDataValid <= wait_q == 3'h1;
      loadByte <= (wait_q == 3'h1) ? byte_q : ~loadByte;
      if (loadReq) begin
        wait_q <= slow ? 3'h4 : 3'h1;
        byte_q <= loadAddr[7:0];
      end else if (wait_q != 3'h0) begin
        wait_q <= wait_q - 3'h1;
      end
    end
  end
endmodule : cjr_mem_model

// ==== tb.sv ====
// Self-checking bench for the execute block.
// Assumes the memory model and checker files are compiled first.
`include "cjr_defines.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, reset = 1'b1, insnValid = 1'b0, compactIsaEnable = 1'b0;
  logic hibernateWbDone = 1'b0, slow = 1'b0, busHold = 1'b0;
  logic [31:0] insnWord = 32'h0;
  logic [63:0] pcIn = 64'h0, srcValue = 64'h0, baseValue = 64'h0;
  logic [63:0] exceptionReturnPc = 64'h0040_1001, errorReturnPc = 64'h8000_0123;
  logic [63:0] pcOut, regWriteData, loadAddr;
  logic [4:0]  regWriteAddr;
  logic [7:0]  loadByte;
  logic isaMode, errorLevelFlag, exceptionLevelFlag, redirectNow, regWriteEn, loadReq;
  logic reservedInsnFault, fetchAddrError, clocksRunning, pipelineFrozen;
  logic loadDataValid, systemAddrDataBusIdle;
  int bad_count = 0, checks = 0, i;
  always #20 clk = ~clk;
  cjr_exec u_dut (.clk, .reset, .insnValid, .insnWord, .pcIn, .srcValue, .baseValue,
    .compactIsaEnable, .hibernateWbDone, .exceptionReturnPc, .errorReturnPc, .loadDataValid,
    .loadByte, .systemAddrDataBusIdle, .pcOut, .isaMode, .errorLevelFlag, .exceptionLevelFlag,
    .redirectNow, .regWriteEn, .regWriteAddr, .regWriteData, .loadAddr, .loadReq,
    .reservedInsnFault, .fetchAddrError, .clocksRunning, .pipelineFrozen);
  cjr_mem_model u_mem (.clk, .reset, .loadReq, .loadAddr, .slow, .busHold, .loadDataValid,
    .loadByte, .systemAddrDataBusIdle);
  // Present one instruction for one rising edge
  task automatic issue(input logic [31:0] w, input logic [63:0] p, input logic [63:0] s);
    insnWord = w;
    pcIn = p;
    srcValue = s;
    baseValue = s;
    insnValid = 1'b1;
    @(negedge clk);
  endtask : issue
  task automatic gap();
    insnValid = 1'b0;
    @(negedge clk);
  endtask : gap
  // Jump, then delay slot; link and target checked
  task automatic jmp(input logic [31:0] w, input logic [63:0] p, input logic [63:0] s,
                     input logic [4:0] ra, input logic [63:0] lk, input logic [63:0] tg,
                     input logic md);
    issue(w, p, s);
    if (ra != 5'h0) `CHK({regWriteEn, regWriteAddr, regWriteData}, {1'b1, ra, lk})
    else `CHK(regWriteEn, 1'b0)
    `CHK({reservedInsnFault, fetchAddrError, pcOut}, {2'b00, p + 64'h4})
    issue(32'h0, p + 64'h4, 64'h0);
    `CHK({redirectNow, isaMode, pcOut}, {1'b1, md, tg})
  endtask : jmp
  // Byte load with base 1000, destination 7
  task automatic ld(input logic [5:0] op, input logic [15:0] off, input logic sl,
                    input logic [63:0] ea, input logic [63:0] rd);
    slow = sl;
    issue({op, 5'h02, 5'h07, off}, 64'h9000, 64'h1000);
    `CHK({loadReq, loadAddr}, {1'b1, ea})
    gap();
    for (i = 0; i < 8 && regWriteEn !== 1'b1; i++) @(negedge clk);
    `CHK({regWriteEn, regWriteAddr, regWriteData}, {1'b1, 5'h07, rd})
  endtask : ld
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  // Watchdog
  initial begin
    #80000;
    bad_count++;
    print_verdict();
  end
  // Main sequence
  initial begin
    repeat (20) @(negedge clk);
    reset = 1'b0;
    `CHK(pcOut, `CJR_PC_RESET)
    `CHK({errorLevelFlag, exceptionLevelFlag, isaMode, clocksRunning, pipelineFrozen}, 5'h12)
    $display("test reset done");
    issue(32'h4200_0018, 64'h100, 64'h0);
    `CHK({redirectNow, errorLevelFlag, pcOut}, {2'b10, 64'h8000_0123})
    compactIsaEnable = 1'b1;
    issue(32'h4200_0018, 64'h200, 64'h0);
    `CHK({redirectNow, pcOut}, {1'b1, 64'h0040_1000})
    `CHK({isaMode, exceptionLevelFlag, errorLevelFlag}, 3'b100)
    $display("test return done");
    jmp({`CJR_OP_JAL, 26'h3ffffff}, 64'h2fff_fffc, 64'h0, 5'h1f, 64'h3000_0005,
        64'h3fff_fffc, 1'b1);
    jmp({6'h00, 5'h04, 15'h0, `CJR_FN_JR}, 64'h3fff_fffc, 64'hffff_ffff_8000_4003, 5'h0,
        64'h0, 64'hffff_ffff_8000_4002, 1'b1);
    jmp({`CJR_OP_JUMP_LINK_TOGGLE_ISA, 26'h10}, 64'h0fff_fffc, 64'h0, 5'h1f, 64'h1000_0005,
        64'h1000_0040, 1'b0);
    compactIsaEnable = 1'b0;
    jmp({6'h00, 5'h03, 5'h0, 5'h05, 5'h0, `CJR_FN_JUMP_LINK_VIA_REGISTER}, 64'h1000_0040, 64'h7002, 5'h05,
        64'h1000_0048, 64'h7002, 1'b0);
    insnValid = 1'b0;
    for (i = 0; i < 3 && fetchAddrError !== 1'b1; i++) @(negedge clk);
    `CHK(fetchAddrError, 1'b1)
    jmp({6'h00, 5'h1f, 5'h0, 5'h1f, 5'h0, `CJR_FN_JUMP_LINK_VIA_REGISTER}, 64'h7100, 64'h8000, 5'h1f,
        64'h7108, 64'h8000, 1'b0);
    issue({`CJR_OP_JUMP_LINK_TOGGLE_ISA, 26'h10}, 64'h8000, 64'h0);
    `CHK({reservedInsnFault, regWriteEn}, 2'b10)
    issue(32'h0, 64'h8004, 64'h0);
    `CHK({redirectNow, pcOut}, {1'b0, 64'h8008})
    gap();
    $display("test jumps done");
    ld(`CJR_OP_LBS, 16'hfff0, 1'b0, 64'h0ff0, 64'hffff_ffff_ffff_fff0);
    ld(`CJR_OP_LBU, 16'h0085, 1'b1, 64'h1085, 64'h85);
    $display("test loads done");
    busHold = 1'b1;
    issue({`CJR_OP_SYSCOP, 1'b1, 19'h0, `CJR_FN_HIB}, 64'ha000, 64'h0);
    hibernateWbDone = 1'b1;
    gap();
    hibernateWbDone = 1'b0;
    repeat (4) @(negedge clk);
    `CHK({pipelineFrozen, clocksRunning}, 2'b11)
    busHold = 1'b0;
    for (i = 0; i < 4 && clocksRunning !== 1'b0; i++) @(negedge clk);
    `CHK(clocksRunning, 1'b0)
    // Instruction offered while asleep must not move the PC
    issue(32'h0, 64'hb000, 64'h0);
    repeat (4) @(negedge clk);
    `CHK({clocksRunning, pcOut}, {1'b0, 64'ha004})
    reset = 1'b1;
    @(negedge clk);
    reset = 1'b0;
    `CHK({clocksRunning, pipelineFrozen, pcOut}, {2'b10, `CJR_PC_RESET})
    $display("test hibernate done");
    print_verdict();
  end
endmodule : tb
